// ---- shared/dscp_pkg.sv ----
package dscp_pkg;
	// Frame layout
	localparam int FRAME_BITS = 24;
	localparam int WORD_BITS = 16;
	localparam int ADDR_MSB = 23;
	localparam int ADDR_LSB = 16;
	localparam int SEL_MSB = 5;
	localparam logic [23:0] SREG_RESET = 24'h000000;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [7:0] RD_PAD = 8'h00;
	// Address codes of a frame
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_DATA = 8'h01;
	localparam logic [7:0] CMD_READ = 8'h02;
	localparam logic [7:0] CMD_CTRL = 8'h55;
	localparam logic [7:0] CMD_RST = 8'h56;
	localparam logic [7:0] CMD_CFG = 8'h57;
	localparam logic [7:0] CMD_GAIN = 8'h58;
	localparam logic [7:0] CMD_OFFS = 8'h59;
	localparam logic [7:0] CMD_WDOG = 8'h95;
	// Readback select codes
	localparam logic [5:0] SEL_CFG = 6'h0b;
	localparam logic [5:0] SEL_GAIN = 6'h13;
	localparam logic [5:0] SEL_OFFS = 6'h17;
	localparam logic [1:0] SEL_STAT = 2'h0;
	localparam logic [1:0] SEL_DATA = 2'h1;
	localparam logic [1:0] SEL_CTRL = 2'h2;
	// Field positions
	localparam int CTRL_CHAIN_BIT = 3;
	localparam int RST_BIT = 0;
	// Link timing for the controller end
	localparam int PCLK_PERIOD_NS = 20;
	localparam int SCLK_PERIOD_NS = 160;
	localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / PCLK_PERIOD_NS / 2;
	localparam int LATCH_HIGH_CYC = 4;
	// Controller APB map
	localparam logic [3:0] APB_TX = 4'h0;
	localparam logic [3:0] APB_CTRL = 4'h4;
	localparam logic [3:0] APB_STAT = 4'h8;
	localparam logic [3:0] APB_RX = 4'hc;
	localparam int START_BIT = 0;
	localparam int BUSY_BIT = 0;
	localparam int DONE_BIT = 1;
	// Controller sequencer states
	typedef enum logic [3:0] {
		DSCP_IDLE = 4'b0001,
		DSCP_LOW = 4'b0010,
		DSCP_HIGH = 4'b0100,
		DSCP_LATCH = 4'b1000
	} dscp_state_t;
endpackage

// ---- shared/dscp_if.sv ----
`timescale 1ns/10ps
interface dscp_if;
	logic sclk; // Serial clock, made by the controller
	logic sdi; // Controller to device data
	logic latch; // Commit strobe, rising edge acts
	logic sdo; // Device to controller data
	modport host (output sclk, output sdi, output latch, input sdo);
	modport dev (input sclk, input sdi, input latch, output sdo);
endinterface

// ---- src/dscp_device.sv ----
`timescale 1ns/10ps
module dscp_device #(
	parameter int RES_BITS = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	dscp_if.dev link,
	input wire logic [dscp_pkg::WORD_BITS-1:0] fault_status,
	output logic [dscp_pkg::WORD_BITS-1:0] output_data_word,
	output logic [dscp_pkg::WORD_BITS-1:0] output_control,
	output logic [dscp_pkg::WORD_BITS-1:0] output_configuration,
	output logic [dscp_pkg::WORD_BITS-1:0] gain_trim,
	output logic [dscp_pkg::WORD_BITS-1:0] offset_trim,
	output logic chain_mode_enable,
	output logic watchdog_restart,
	output logic soft_reset_pulse
);
	import dscp_pkg::*;

	// High bits that the narrow variant keeps
	localparam logic [15:0] RES_MASK =
		~((16'h0001 << (WORD_BITS - RES_BITS)) - 16'h0001);

	// Keep only the implemented resolution bits
	function automatic logic [15:0] res_trim(input logic [15:0] v);
		res_trim = v & RES_MASK;
	endfunction

	// Two-stage synchronisers; sclk and latch add one history stage
	logic sclk_m_r, sclk_s_r, sclk_d_r;
	logic sdi_m_r, sdi_s_r;
	logic lat_m_r, lat_s_r, lat_d_r;
	logic [23:0] sreg_r; // Input shift register
	logic rd_active_r; // Readback frame in progress
	logic sdo_r; // Serial output flop
	logic [15:0] data_r, ctrl_r, cfg_r, gain_r, offs_r;
	logic wdog_r, srst_r; // Command pulses

	// Link edges, seen only past the second stage
	wire sclk_rise = sclk_s_r & ~sclk_d_r;
	wire sclk_fall = ~sclk_s_r & sclk_d_r;
	wire commit = lat_s_r & ~lat_d_r;

	// Frame fields
	wire [7:0] cmd_addr = sreg_r[ADDR_MSB:ADDR_LSB];
	wire [15:0] cmd_word = sreg_r[WORD_BITS-1:0];
	wire [5:0] rd_sel = cmd_word[SEL_MSB:0];

	// Command decode on the strobe edge
	wire do_data = commit & (cmd_addr == CMD_DATA);
	wire do_ctrl = commit & (cmd_addr == CMD_CTRL);
	wire do_cfg = commit & (cmd_addr == CMD_CFG);
	wire do_gain = commit & (cmd_addr == CMD_GAIN);
	wire do_offs = commit & (cmd_addr == CMD_OFFS);
	wire do_read = commit & (cmd_addr == CMD_READ);
	wire do_wdog = commit & (cmd_addr == CMD_WDOG);
	// Reset register only acts, it keeps nothing
	wire do_srst = commit & (cmd_addr == CMD_RST)
		& cmd_word[RST_BIT];

	// Readback select: full codes first, then low two bits
	wire sel_cfg = (rd_sel == SEL_CFG);
	wire sel_gain = (rd_sel == SEL_GAIN);
	wire sel_offs = (rd_sel == SEL_OFFS);
	wire sel_stat = (rd_sel[1:0] == SEL_STAT);
	wire sel_data = (rd_sel[1:0] == SEL_DATA);
	wire sel_ctrl = (rd_sel[1:0] == SEL_CTRL);
	wire [15:0] rd_val =
		sel_cfg ? cfg_r :
		sel_gain ? res_trim(gain_r) :
		sel_offs ? res_trim(offs_r) :
		sel_stat ? fault_status :
		sel_data ? res_trim(data_r) :
		sel_ctrl ? ctrl_r :
		REG_RESET; // Unlisted select reads zero

	// Output drives the stream in chain mode or during readback
	wire sdo_live = ctrl_r[CTRL_CHAIN_BIT] | rd_active_r;

	// Synchronise the link pins into pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_m_r <= 1'b0;
			sclk_s_r <= 1'b0;
			sclk_d_r <= 1'b0;
			sdi_m_r <= 1'b0;
			sdi_s_r <= 1'b0;
			lat_m_r <= 1'b0;
			lat_s_r <= 1'b0;
			lat_d_r <= 1'b0;
		end else begin
			sclk_m_r <= link.sclk;
			sclk_s_r <= sclk_m_r;
			sclk_d_r <= sclk_s_r;
			sdi_m_r <= link.sdi;
			sdi_s_r <= sdi_m_r;
			lat_m_r <= link.latch;
			lat_s_r <= lat_m_r;
			lat_d_r <= lat_s_r;
		end
	end

	// Shift register: reset and readback load beat shifting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sreg_r <= SREG_RESET;
		end else if (do_srst) begin
			sreg_r <= SREG_RESET;
		end else if (do_read) begin
			// Register lands at the top so it leaves first
			sreg_r <= {rd_val, RD_PAD};
		end else if (sclk_rise) begin
			// Strobe level does not gate shifting
			sreg_r <= {sreg_r[22:0], sdi_s_r};
		end
	end

	// Serial output changes on falling edges and on a readback commit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sdo_r <= 1'b0;
			rd_active_r <= 1'b0;
		end else begin
			// A readback frame lasts until the next commit
			if (commit) begin
				rd_active_r <= do_read;
			end
			if (do_read) begin
				sdo_r <= rd_val[WORD_BITS-1];
			end else if (sclk_fall) begin
				// Top bit is what the next rise pushes out
				sdo_r <= sdo_live & sreg_r[23];
			end
		end
	end

	// Register writes on commit; nop and readback store nothing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_r <= REG_RESET;
			ctrl_r <= REG_RESET;
			cfg_r <= REG_RESET;
			gain_r <= REG_RESET;
			offs_r <= REG_RESET;
		end else if (do_srst) begin
			// Soft reset returns every register to default
			data_r <= REG_RESET;
			ctrl_r <= REG_RESET;
			cfg_r <= REG_RESET;
			gain_r <= REG_RESET;
			offs_r <= REG_RESET;
		end else begin
			if (do_data) begin
				data_r <= res_trim(cmd_word);
			end
			if (do_ctrl) begin
				ctrl_r <= cmd_word;
			end
			if (do_cfg) begin
				cfg_r <= cmd_word;
			end
			if (do_gain) begin
				gain_r <= res_trim(cmd_word);
			end
			if (do_offs) begin
				offs_r <= res_trim(cmd_word);
			end
		end
	end

	// One-cycle command pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdog_r <= 1'b0;
			srst_r <= 1'b0;
		end else begin
			wdog_r <= do_wdog;
			srst_r <= do_srst;
		end
	end

	// All outputs come straight from flops
	assign link.sdo = sdo_r;
	assign output_data_word = data_r;
	assign output_control = ctrl_r;
	assign output_configuration = cfg_r;
	assign gain_trim = gain_r; // Unsigned
	assign offset_trim = offs_r; // Two's complement
	assign chain_mode_enable = ctrl_r[CTRL_CHAIN_BIT];
	assign watchdog_restart = wdog_r;
	assign soft_reset_pulse = srst_r;
endmodule // dscp_device

// ---- src/dscp_host.sv ----
`timescale 1ns/10ps
// Serial controller: software fills a frame over APB and
// starts it; the block clocks it out, strobes, and keeps sdo.
module dscp_host #(
	parameter int CHAIN_LEN = 1,
	parameter int HALF_CYC = dscp_pkg::SCLK_HALF_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	dscp_if.host link
);
	import dscp_pkg::*;

	localparam int FW = CHAIN_LEN * FRAME_BITS;
	localparam int CW = $clog2(FW + 1);

	dscp_state_t st_r; // Sequencer state
	logic [FW-1:0] tx_r, rx_r; // Outgoing and captured frames
	logic [CW-1:0] bits_r; // Bits still to send
	logic [7:0] tick_r; // Phase timer
	logic sclk_r, sdi_r, lat_r;
	logic sdo_m_r, sdo_s_r; // sdo synchroniser
	logic done_r;
	logic [31:0] prdata_r;
	logic pslverr_r;

	// APB decode; the setup cycle prepares the answer
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire hit = (paddr[31:4] == 28'h0000000) & (paddr[1:0] == 2'b00);
	wire [3:0] off = paddr[3:0];
	wire wr = access & pwrite & ~pslverr_r;
	wire wr_tx = wr & (off == APB_TX);
	wire wr_go = wr & (off == APB_CTRL) & pwdata[START_BIT];
	wire wr_clr = wr & (off == APB_STAT) & pwdata[DONE_BIT];
	wire rd_rx = access & ~pwrite & ~pslverr_r & (off == APB_RX);
	wire idle = (st_r == DSCP_IDLE);
	wire tick_end = (tick_r == 8'(HALF_CYC - 1));
	wire last_bit = (bits_r == CW'(1));
	wire frame_end = (st_r == DSCP_LATCH)
		& (tick_r == 8'(LATCH_HIGH_CYC - 1));
	wire [31:0] stat_word = {30'h0, done_r, ~idle};
	wire [31:0] rd_mux =
		(off == APB_STAT) ? stat_word :
		(off == APB_RX) ? {8'h00, rx_r[FW-1 -: FRAME_BITS]} :
		32'h00000000;

	// APB slave: zero wait, error on unmapped offsets
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else if (setup) begin
			prdata_r <= rd_mux;
			pslverr_r <= ~hit;
		end
	end

	// sdo arrives from the device domain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sdo_m_r <= 1'b0;
			sdo_s_r <= 1'b0;
		end else begin
			sdo_m_r <= link.sdo;
			sdo_s_r <= sdo_m_r;
		end
	end

	// Frame sequencer; start is ignored while busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= DSCP_IDLE;
			tx_r <= '0;
			rx_r <= '0;
			bits_r <= '0;
			tick_r <= 8'h00;
			sclk_r <= 1'b0;
			sdi_r <= 1'b0;
			lat_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			// Done sets over a clear in the same cycle
			if (frame_end) begin
				done_r <= 1'b1;
			end else if (wr_clr) begin
				done_r <= 1'b0;
			end
			// RX words pop farthest device first
			if (rd_rx & idle) begin
				rx_r <= rx_r << FRAME_BITS;
			end
			case (st_r)
				DSCP_IDLE: begin
					tick_r <= 8'h00;
					if (wr_tx) begin
						// Words fill farthest device first; the cast
						// keeps a one-device frame legal
						tx_r <= FW'({tx_r,
							pwdata[FRAME_BITS-1:0]});
					end else if (wr_go) begin
						bits_r <= CW'(FW);
						sdi_r <= tx_r[FW-1];
						st_r <= DSCP_LOW;
					end
				end
				DSCP_LOW: begin
					tick_r <= tick_end ? 8'h00 : tick_r + 8'h01;
					if (tick_end) begin
						sclk_r <= 1'b1;
						st_r <= DSCP_HIGH;
					end
				end
				DSCP_HIGH: begin
					tick_r <= tick_end ? 8'h00 : tick_r + 8'h01;
					if (tick_end) begin
						// Sample late in the high phase
						rx_r <= {rx_r[FW-2:0], sdo_s_r};
						tx_r <= tx_r << 1;
						sdi_r <= tx_r[FW-2];
						sclk_r <= 1'b0;
						bits_r <= bits_r - CW'(1);
						// Exact burst, then strobe after last clock
						st_r <= last_bit ? DSCP_LATCH : DSCP_LOW;
						lat_r <= last_bit;
					end
				end
				DSCP_LATCH: begin
					tick_r <= tick_r + 8'h01;
					if (frame_end) begin
						lat_r <= 1'b0;
						st_r <= DSCP_IDLE;
					end
				end
				default: begin
					st_r <= DSCP_IDLE;
				end
			endcase
		end
	end

	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = pslverr_r;
	assign link.sclk = sclk_r;
	assign link.sdi = sdi_r;
	assign link.latch = lat_r;
endmodule // dscp_host

// ---- sim/dscp_monitor.sv ----
`timescale 1ns/10ps
// Timing and framing checks on the serial wires
module dscp_monitor #(
	parameter int CHAIN_LEN = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic latch,
	input wire logic sdo
);
	default clocking mon_cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic sclk_q_r; // Serial clock one cycle ago
	logic [7:0] rise_cnt_r; // Rising edges since last commit
	wire sclk_rise = sclk && !sclk_q_r; // Edge found in pclk domain
	// Count edges per frame; a commit clears the count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_q_r <= 1'b0;
			rise_cnt_r <= 8'h00;
		end else begin
			sclk_q_r <= sclk;
			if (latch)
				rise_cnt_r <= 8'h00;
			else if (sclk_rise)
				rise_cnt_r <= rise_cnt_r + 8'h01;
		end
	end
	sequence s_high_phase;
		sclk [*4] ##1 !sclk;
	endsequence
	sequence s_low_phase;
		!sclk [*4];
	endsequence
	property p_sclk_high;
		$rose(sclk) |-> s_high_phase;
	endproperty
	a_sclk_high: assert property (p_sclk_high)
		else $error("serial clock high phase wrong");
	property p_sclk_low;
		$fell(sclk) |-> s_low_phase;
	endproperty
	a_sclk_low: assert property (p_sclk_low)
		else $error("serial clock low phase too short");
	property p_sdi_hold;
		sclk && $past(sclk) |-> $stable(sdi);
	endproperty
	a_sdi_hold: assert property (p_sdi_hold)
		else $error("data in moved while clock high");
	property p_frame_count;
		$rose(latch) |-> rise_cnt_r == 8'(24 * CHAIN_LEN);
	endproperty
	a_frame_count: assert property (p_frame_count)
		else $error("commit after wrong edge count");
	property p_latch_len;
		$rose(latch) |-> latch [*4] ##1 !latch;
	endproperty
	a_latch_len: assert property (p_latch_len)
		else $error("commit strobe width wrong");
	property p_latch_end;
		$rose(latch) |-> $fell(sclk);
	endproperty
	a_latch_end: assert property (p_latch_end)
		else $error("strobe not right after last clock");
	property p_after_latch;
		$fell(latch) |-> !sclk [*3];
	endproperty
	a_after_latch: assert property (p_after_latch)
		else $error("clock too soon after commit");
	property p_sdo_hold;
		sclk && $past(sclk) |-> $stable(sdo);
	endproperty
	a_sdo_hold: assert property (p_sdo_hold)
		else $error("data out moved while clock high");
endmodule // dscp_monitor

// ---- sim/tb.sv ----
`timescale 1ns/10ps
// Both link ends joined; driven over APB, checked by notes
module tb;
	import dscp_pkg::*;
	typedef struct {
		string nm;
		logic [31:0] v;
	} dscp_note_t;
	logic pclk, presetn, psel, penable, pwrite;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic pready, pslverr, wdog, srst;
	logic [15:0] fault_status, v, c;
	logic [15:0] vals[5];
	logic [15:0] outs[5]; // Register outputs, in command order
	logic chain; // Chain enable output
	logic [2:0] look; // Output shown to the watcher, 0 for none
	int err_total, comparisons;
	dscp_note_t notes[$]; // Expected results, oldest first
	logic [7:0] cmds[5] = '{CMD_DATA, CMD_CTRL, CMD_CFG, CMD_GAIN, CMD_OFFS};
	// Upper select bits set on purpose: they must be ignored
	logic [5:0] sels[5] = '{6'h21, 6'h1e, SEL_CFG, SEL_GAIN, SEL_OFFS};
	dscp_if link ();
	dscp_host #(.CHAIN_LEN(1), .HALF_CYC(4)) dscp_host_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(link.host));
	dscp_device #(.RES_BITS(16)) dscp_device_i (
		.pclk(pclk), .presetn(presetn), .link(link.dev),
		.fault_status(fault_status), .output_data_word(outs[0]),
		.output_control(outs[1]), .output_configuration(outs[2]),
		.gain_trim(outs[3]), .offset_trim(outs[4]),
		.chain_mode_enable(chain), .watchdog_restart(wdog),
		.soft_reset_pulse(srst));
	dscp_monitor #(.CHAIN_LEN(1)) dscp_monitor_i (
		.pclk(pclk), .presetn(presetn), .sclk(link.sclk),
		.sdi(link.sdi), .latch(link.latch), .sdo(link.sdo));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task automatic close_out();
		if (notes.size() != 0) begin
			err_total++;
			$display("MISMATCH notes expected 0 seen %0d", notes.size());
		end
		$display("Checks %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// A bounded wait that ran out ends the run
	task automatic bail(input string what);
		err_total++;
		$display("MISMATCH %s expected done seen timeout", what);
		close_out();
	endtask
	task automatic note(input string nm, input logic [31:0] x);
		notes.push_back('{nm, x});
	endtask
	task automatic take(input string nm, input logic [31:0] x);
		dscp_note_t e;
		e = '{"none", 32'h0};
		if (notes.size() > 0)
			e = notes.pop_front();
		comparisons++;
		if (e.nm != nm || e.v !== x) begin
			err_total++;
			$display("MISMATCH %s expected %s %h seen %h", nm, e.nm, e.v, x);
		end
	endtask
	// Watcher: every result seen is paired with the oldest note
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && paddr == 32'(APB_RX))
			take("rx", {8'h00, prdata[23:0]});
		if (psel && penable && pslverr === 1'b1)
			take("slverr", 32'h1);
		if (wdog === 1'b1)
			take("wdog", 32'h0);
		if (srst === 1'b1)
			take("srst", 32'h0);
		if (look != 3'h0)
			take("out", {15'h0, chain, outs[look - 3'h1]});
	end
	// One APB transfer; held until pready is seen high
	task automatic apb(input logic wr, input logic [31:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		// Release at once so no second access phase follows
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20)
			bail("pready");
		@(posedge pclk);
	endtask
	// Send one frame, poll until done, clear the sticky flag
	task automatic frame(input logic [7:0] a, input logic [15:0] d);
		int n;
		apb(1'b1, 32'(APB_TX), {8'h00, a, d});
		apb(1'b1, 32'(APB_CTRL), 32'h1);
		for (n = 0; n < 200; n++) begin
			apb(1'b0, 32'(APB_STAT), 32'h0);
			if (rd[DONE_BIT] === 1'b1)
				break;
		end
		if (n == 200)
			bail("frame");
		apb(1'b1, 32'(APB_STAT), 32'h2);
	endtask
	// Request a register, clock it out with a second frame
	task automatic readback(input logic [5:0] s, input logic [15:0] e);
		frame(CMD_READ, {10'($urandom()), s});
		frame(CMD_NOP, 16'($urandom()));
		note("rx", {8'h00, e, 8'h00});
		apb(1'b0, 32'(APB_RX), 32'h0);
	endtask
	// Show one register output to the watcher for one edge
	task automatic peek(input logic [2:0] k, input logic [16:0] x);
		note("out", {15'h0, x});
		look <= k;
		@(posedge pclk);
		look <= 3'h0;
		@(posedge pclk);
	endtask
	initial begin
		void'($urandom(67));
		{presetn, psel, penable, pwrite} = 4'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
		look = 3'h0;
		fault_status = 16'($urandom());
		err_total = 0;
		comparisons = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		// Chain bit kept clear here so readback stays stand-alone
		for (int i = 0; i < 5; i++) begin
			readback(sels[i], 16'h0000);
			vals[i] = 16'($urandom()) & ~16'h0008;
			frame(cmds[i], vals[i]);
			readback(sels[i], vals[i]);
		end
		// Register outputs match what was written
		for (int i = 0; i < 5; i++) begin
			peek(3'(i + 1), {1'b0, vals[i]});
		end
		readback(6'h3c, fault_status);
		readback(6'h3f, 16'h0000);
		frame(CMD_NOP, 16'hffff);
		frame(8'h33, 16'hffff);
		note("wdog", 32'h0);
		frame(CMD_WDOG, 16'hffff);
		frame(CMD_RST, 16'hfffe);
		readback(6'h01, vals[0]);
		note("srst", 32'h0);
		frame(CMD_RST, 16'h0001);
		readback(6'h01, 16'h0000);
		peek(3'h1, 17'h00000);
		note("slverr", 32'h1);
		apb(1'b1, 32'h10, 32'hffffffff);
		note("slverr", 32'h1);
		apb(1'b0, 32'h6, 32'h0);
		// Chain mode: data out is the previous frame
		c = 16'($urandom()) | 16'h0008;
		frame(CMD_CTRL, c);
		peek(3'h2, {1'b1, c});
		v = 16'($urandom());
		frame(CMD_NOP, v);
		note("rx", {8'h00, CMD_CTRL, c});
		apb(1'b0, 32'(APB_RX), 32'h0);
		frame(CMD_READ, {10'h3ff, sels[1]});
		note("rx", {8'h00, CMD_NOP, v});
		apb(1'b0, 32'(APB_RX), 32'h0);
		frame(CMD_NOP, 16'h0000);
		note("rx", {8'h00, c, 8'h00});
		apb(1'b0, 32'(APB_RX), 32'h0);
		// Second reset in mid-run clears the chain setting
		psel <= 1'b0;
		penable <= 1'b0;
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		readback(sels[1], 16'h0000);
		peek(3'h2, 17'h00000);
		repeat (4) @(posedge pclk);
		close_out();
	end
endmodule // tb
